// [logic/ifdc_pkg.sv]
// Purpose: shared constants for the flush, dma enable and spike filter control block
// Assumes: system clock ref_clk at 250 MHz, separate i2c link clock
// Notes: bit positions mirror the upper control word layout
package ifdc_pkg;
  localparam int unsigned TX_FLUSH_BIT = 7;
  localparam int unsigned RX_FLUSH_BIT = 8;
  localparam int unsigned DMA_TX_EN_BIT = 9;
  localparam int unsigned DMA_RX_EN_BIT = 10;
  localparam int unsigned FILT_LO_BIT = 13;
  localparam int unsigned FILT_HI_BIT = 14;
  localparam logic [1:0] FILT_RESET = 2'h0;
  localparam logic [1:0] FILT_OFF = 2'h0;
  localparam logic [1:0] FILT_ONE = 2'h1;
  localparam logic [1:0] FILT_TWO = 2'h2;
  localparam logic [1:0] FILT_FOUR = 2'h3;
  localparam logic [2:0] FILT_CNT_ONE = 3'h1;
  localparam logic [2:0] FILT_CNT_TWO = 3'h2;
  localparam logic [2:0] FILT_CNT_FOUR = 3'h4;
  localparam int unsigned SYNC_STAGES = 2;
  typedef enum logic [1:0] {
    IFDC_FL_IDLE = 2'b00,
    IFDC_FL_REQ = 2'b01,
    IFDC_FL_DROP = 2'b10
  } ifdc_fl_state_t;
endpackage

// [logic/ifdc_flush_link.sv]
// Purpose: link-domain side of one flush: four-phase handshake with the system domain
// Assumes: link clock may stop; request level held until acknowledge seen
// Notes: flush_pulse is one link clock wide, used to clear link fifo and state machine
module ifdc_flush_link
  import ifdc_pkg::*;
(
  input wire logic link_clk, // i2c clock
  input wire logic link_rst, // link reset, sync active high
  input wire logic req_in, // request level from system domain
  output logic ack_out, // acknowledge level back to system domain
  output logic flush_pulse // one-cycle flush in link domain
);
  logic s1_q, s2_q, ack_q, ack_d, pulse_q, pulse_d;

  // next values: ack follows synchronised request, pulse on its rise
  always_comb begin
    ack_d = s2_q;
    pulse_d = s2_q & ~ack_q;
  end

  // two-stage synchroniser, first stage read only by the second
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      ack_q <= 1'b0;
      pulse_q <= 1'b0;
    end else begin
      s1_q <= req_in;
      s2_q <= s1_q;
      ack_q <= ack_d;
      pulse_q <= pulse_d;
    end
  end

  assign ack_out = ack_q;
  assign flush_pulse = pulse_q;
endmodule

// [logic/ifdc_ctrl.sv]
// Purpose: flush, dma enable and spike filter part of the i2c control word
// Assumes: software keeps off fifos during a flush and never sets both dma enables
// Notes: flushes cross to the link clock by a four-phase handshake
module ifdc_ctrl
  import ifdc_pkg::*;
(
  input wire logic ref_clk, // system clock
  input wire logic rst, // system reset, sync active high
  input wire logic link_clk, // i2c clock
  input wire logic link_rst, // link reset, sync active high
  input wire logic node_on, // peripheral enable, low is soft reset
  input wire logic tx_flush_set, // write one pulse to tx flush bit
  input wire logic rx_flush_set, // write one pulse to rx flush bit
  input wire logic dma_wr, // write strobe for dma enable bits
  input wire logic dma_tx_en_wdata, // data for dma tx enable
  input wire logic dma_rx_en_wdata, // data for dma rx enable
  input wire logic dma_eot, // end of transfer pulse from dma
  input wire logic filt_wr, // write strobe for filter field
  input wire logic [1:0] spike_filter_wdata, // filter field write data
  input wire logic sda_in, // raw sda pin, link domain
  input wire logic scl_in, // raw scl pin, link domain
  output logic tx_flush, // tx flush bit readback
  output logic rx_flush, // rx flush bit readback
  output logic dma_tx_en, // dma tx interface running
  output logic dma_rx_en, // dma rx interface running
  output logic [1:0] spike_filter_select, // filter field readback
  output logic tx_link_flush, // tx fifo/fsm clear, link domain pulse
  output logic rx_link_flush, // rx fifo/fsm clear, link domain pulse
  output logic sda_filt, // filtered sda, link domain
  output logic scl_filt // filtered scl, link domain
);
  ifdc_fl_state_t tx_st_q, tx_st_d, rx_st_q, rx_st_d;
  logic tx_ack, rx_ack, tx_a1_q, tx_a2_q, rx_a1_q, rx_a2_q;
  logic txe_q, txe_d, rxe_q, rxe_d;
  logic [1:0] filt_q, filt_d;
  logic soft_rst;
  logic tx_lk_rst, rx_lk_rst;

  assign soft_rst = rst | ~node_on;

  // flush sequencer step: idle, raise request, wait ack drop
  function automatic ifdc_fl_state_t fl_next(ifdc_fl_state_t s, logic set, logic ack);
    ifdc_fl_state_t n;
    n = s;
    unique case (s)
      IFDC_FL_IDLE: if (set) n = IFDC_FL_REQ;
      IFDC_FL_REQ: if (ack) n = IFDC_FL_DROP;
      IFDC_FL_DROP: if (!ack) n = IFDC_FL_IDLE;
      default: n = IFDC_FL_IDLE;
    endcase
    return n;
  endfunction

  // control next values; end of transfer beats a same-cycle write
  always_comb begin
    tx_st_d = fl_next(tx_st_q, tx_flush_set, tx_a2_q);
    rx_st_d = fl_next(rx_st_q, rx_flush_set, rx_a2_q);
    txe_d = dma_wr ? dma_tx_en_wdata : txe_q;
    rxe_d = dma_wr ? dma_rx_en_wdata : rxe_q;
    if (dma_eot) begin
      txe_d = 1'b0;
      rxe_d = 1'b0;
    end
    filt_d = filt_wr ? spike_filter_wdata : filt_q;
  end

  // registers; flush sequencers only use hard reset so a handshake never breaks
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tx_st_q <= IFDC_FL_IDLE;
      rx_st_q <= IFDC_FL_IDLE;
      tx_a1_q <= 1'b0;
      tx_a2_q <= 1'b0;
      rx_a1_q <= 1'b0;
      rx_a2_q <= 1'b0;
    end else begin
      tx_st_q <= tx_st_d;
      rx_st_q <= rx_st_d;
      tx_a1_q <= tx_ack;
      tx_a2_q <= tx_a1_q;
      rx_a1_q <= rx_ack;
      rx_a2_q <= rx_a1_q;
    end
  end

  // configuration bits, cleared by node_on low
  always_ff @(posedge ref_clk) begin
    if (soft_rst) begin
      txe_q <= 1'b0;
      rxe_q <= 1'b0;
      filt_q <= FILT_RESET;
    end else begin
      txe_q <= txe_d;
      rxe_q <= rxe_d;
      filt_q <= filt_d;
    end
  end

  // busy while request raised or ack not yet dropped
  assign tx_flush = (tx_st_q != IFDC_FL_IDLE);
  assign rx_flush = (rx_st_q != IFDC_FL_IDLE);
  assign dma_tx_en = txe_q;
  assign dma_rx_en = rxe_q;
  assign spike_filter_select = filt_q;

  assign tx_lk_rst = link_rst;
  assign rx_lk_rst = link_rst;

  ifdc_flush_link u_tx_link (
    .link_clk(link_clk),
    .link_rst(tx_lk_rst),
    .req_in(tx_st_q == IFDC_FL_REQ),
    .ack_out(tx_ack),
    .flush_pulse(tx_link_flush)
  );

  ifdc_flush_link u_rx_link (
    .link_clk(link_clk),
    .link_rst(rx_lk_rst),
    .req_in(rx_st_q == IFDC_FL_REQ),
    .ack_out(rx_ack),
    .flush_pulse(rx_link_flush)
  );

  // filter setting crosses as a level; the link side keeps a copy only once two samples agree
  logic [1:0] fs1_q, fs2_q, fs3_q, filt_lk_q, filt_lk_d;
  logic [1:0] pin_s1_q, pin_s2_q, pin_o_q, pin_o_d;
  logic [2:0] cnt_q [2];
  logic [2:0] cnt_d [2];
  logic [2:0] limit;

  // take the setting only when two synchronised samples agree, so a torn two-bit change never reaches the filter
  always_comb begin
    filt_lk_d = (fs2_q == fs3_q) ? fs3_q : filt_lk_q;
    unique case (filt_lk_q)
      FILT_OFF: limit = 3'h0;
      FILT_ONE: limit = FILT_CNT_ONE;
      FILT_TWO: limit = FILT_CNT_TWO;
      FILT_FOUR: limit = FILT_CNT_FOUR;
    endcase
  end

  // per line: accept a change only once it has stood longer than the spike width
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_filt
      always_comb begin
        pin_o_d[g] = pin_o_q[g];
        cnt_d[g] = 3'h0;
        if (pin_s2_q[g] != pin_o_q[g]) begin
          if (cnt_q[g] >= limit) begin
            pin_o_d[g] = pin_s2_q[g];
          end else begin
            cnt_d[g] = cnt_q[g] + 3'h1;
          end
        end
      end
    end
  endgenerate

  // link side registers: pin and setting synchronisers, filter state
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      fs1_q <= 2'h0;
      fs2_q <= 2'h0;
      fs3_q <= FILT_RESET;
      filt_lk_q <= FILT_RESET;
      pin_s1_q <= 2'h3;
      pin_s2_q <= 2'h3;
      pin_o_q <= 2'h3;
      cnt_q[0] <= 3'h0;
      cnt_q[1] <= 3'h0;
    end else begin
      fs1_q <= filt_q;
      fs2_q <= fs1_q;
      fs3_q <= fs2_q;
      filt_lk_q <= filt_lk_d;
      pin_s1_q <= {scl_in, sda_in};
      pin_s2_q <= pin_s1_q;
      pin_o_q <= pin_o_d;
      cnt_q[0] <= cnt_d[0];
      cnt_q[1] <= cnt_d[1];
    end
  end

  assign sda_filt = pin_o_q[0];
  assign scl_filt = pin_o_q[1];

  // assertions, system domain
  flush_clears_ack_a: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(tx_flush) |-> $past(tx_a2_q) == 1'b0 && $past(tx_st_q) == IFDC_FL_DROP)
    else $error("tx flush cleared without acknowledge");
  tx_flush_start_a: assert property (@(posedge ref_clk) disable iff (rst)
    !tx_flush && tx_flush_set |=> tx_flush)
    else $error("tx flush bit not set");
  rx_flush_start_a: assert property (@(posedge ref_clk) disable iff (rst)
    !rx_flush && rx_flush_set |=> rx_flush [*2])
    else $error("rx flush bit not held");
  rx_flush_done_a: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(rx_flush) |-> $past(rx_st_q) == IFDC_FL_DROP)
    else $error("rx flush ended out of order");
  dma_eot_clear_a: assert property (@(posedge ref_clk) disable iff (soft_rst)
    dma_eot |=> !dma_tx_en && !dma_rx_en)
    else $error("dma enable survived end of transfer");
  dma_tx_write_a: assert property (@(posedge ref_clk) disable iff (soft_rst)
    dma_wr && !dma_eot |=> dma_tx_en == $past(dma_tx_en_wdata))
    else $error("dma tx enable write lost");
  dma_rx_hold_a: assert property (@(posedge ref_clk) disable iff (soft_rst)
    !dma_wr && !dma_eot |=> $stable(dma_rx_en))
    else $error("dma rx enable changed unprompted");
  node_off_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
    !node_on |=> !dma_tx_en && !dma_rx_en && spike_filter_select == FILT_RESET)
    else $error("node off did not reset configuration");
  filt_write_a: assert property (@(posedge ref_clk) disable iff (soft_rst)
    filt_wr |=> spike_filter_select == $past(spike_filter_wdata))
    else $error("filter field write lost");
  // link domain: with filtering off a settled change passes in one cycle
  filt_off_pass_a: assert property (@(posedge link_clk) disable iff (link_rst)
    filt_lk_q == FILT_OFF && $stable(filt_lk_q) && pin_s2_q[0] != pin_o_q[0]
    |=> sda_filt == $past(pin_s2_q[0]))
    else $error("unfiltered sda not passed");
  filt_four_hold_a: assert property (@(posedge link_clk) disable iff (link_rst)
    filt_lk_q == FILT_FOUR && $changed(pin_s2_q[1]) && pin_s2_q[1] != scl_filt |=> $stable(scl_filt))
    else $error("scl spike passed filter");

  tx_flush_cov: cover property (@(posedge ref_clk) disable iff (rst) $fell(tx_flush));
  rx_flush_cov: cover property (@(posedge ref_clk) disable iff (rst) $fell(rx_flush));
  dma_eot_cov: cover property (@(posedge ref_clk) disable iff (soft_rst) dma_tx_en && dma_eot);
  filt_cov: cover property (@(posedge link_clk) disable iff (link_rst) filt_lk_q == FILT_FOUR && $changed(sda_filt));
endmodule

// [testbench/ifdc_bus_partner.sv]
// Purpose: far-side i2c device that pulls sda or scl low for a set number of link cycles
// Assumes: open-drain lines with pull-ups, so a released line reads one
// Notes: the glitch widths are commanded only by the bench
module ifdc_bus_partner (
  output logic sda_line, // sda level seen at the pin
  output logic scl_line, // scl level seen at the pin
  input wire logic link_clk // i2c clock
);
  timeunit 1ns;
  timeprecision 100ps;
  // released lines float up to the pull-up level
  initial begin
    sda_line = 1'b1;
    scl_line = 1'b1;
  end
  // pull one line low for w link cycles, changing just after a link edge
  task automatic pull(input logic line, input int w);
    @(posedge link_clk);
    #1;
    if (line) scl_line = 1'b0;
    else sda_line = 1'b0;
    repeat (w) @(posedge link_clk);
    #1;
    sda_line = 1'b1;
    scl_line = 1'b1;
  endtask
endmodule

// [testbench/test_ifdc_ctrl.sv]
// Purpose: self-checking bench for the flush, dma enable and spike filter block
// Assumes: link clock of 48 ns, never aligned with ref_clk edges
// Notes: random dma and filter writes from a fixed seed, then flushes and glitch tests
module test_ifdc_ctrl;
  timeunit 1ns;
  timeprecision 100ps;
  import ifdc_pkg::*;
  logic ref_clk = 1'b0, link_clk = 1'b0, rst = 1'b1, link_rst = 1'b1, node_on = 1'b1;
  logic tx_set = 1'b0, rx_set = 1'b0, dma_wr = 1'b0, tdat = 1'b0, rdat = 1'b0, eot = 1'b0, filt_wr = 1'b0;
  logic [1:0] fdat = 2'h0, sel, e_filt = 2'h0;
  logic tx_fl, rx_fl, dtx, drx, tlf, rlf, sda_f, scl_f, sda, scl, e_tx = 1'b0, e_rx = 1'b0;
  int err_count = 0, comparisons = 0, seed = 56456, tx_p = 0, rx_p = 0, sda_lo = 0, scl_lo = 0;

  ifdc_bus_partner p (.sda_line(sda), .scl_line(scl), .link_clk(link_clk));
  ifdc_ctrl uut (.ref_clk(ref_clk), .rst(rst), .link_clk(link_clk), .link_rst(link_rst), .node_on(node_on),
    .tx_flush_set(tx_set), .rx_flush_set(rx_set), .dma_wr(dma_wr), .dma_tx_en_wdata(tdat),
    .dma_rx_en_wdata(rdat), .dma_eot(eot), .filt_wr(filt_wr), .spike_filter_wdata(fdat), .sda_in(sda),
    .scl_in(scl), .tx_flush(tx_fl), .rx_flush(rx_fl), .dma_tx_en(dtx), .dma_rx_en(drx),
    .spike_filter_select(sel), .tx_link_flush(tlf), .rx_link_flush(rlf), .sda_filt(sda_f), .scl_filt(scl_f));

  // system clock, 250 MHz
  always #2 ref_clk = ~ref_clk;
  // odd offset keeps link edges off ref_clk edges
  initial begin
    #7;
    forever #24 link_clk = ~link_clk;
  end
  // link reset must see at least two link edges
  initial begin
    repeat (3) @(posedge link_clk);
    link_rst <= 1'b0;
  end
  // count link clear pulses and low cycles on the filtered lines; only this process writes them, tasks take differences
  always @(posedge link_clk) begin
    if (tlf === 1'b1) tx_p++;
    if (rlf === 1'b1) rx_p++;
    if (sda_f !== 1'b1) sda_lo++;
    if (scl_f !== 1'b1) scl_lo++;
  end

  task automatic chk(input logic [1:0] got, input logic [1:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_cnt(input int got, input int exp);
    comparisons++;
    if (got != exp) begin
      err_count++;
      $display("Error at %0t: count %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // one flush, plus a second write while busy that must be ignored
  task automatic flush(input logic rx);
    int n, t0, r0;
    t0 = tx_p;
    r0 = rx_p;
    for (int k = 0; k < 2; k++) begin
      @(posedge ref_clk);
      rx_set <= rx;
      tx_set <= ~rx;
      @(posedge ref_clk);
      rx_set <= 1'b0;
      tx_set <= 1'b0;
      #1;
      chk({rx_fl, tx_fl}, {rx, ~rx});
    end
    // poll as software must, keeping off the fifos meanwhile
    for (n = 0; n < 500 && (tx_fl !== 1'b0 || rx_fl !== 1'b0); n++) begin
      @(posedge ref_clk);
      #1;
    end
    if (n == 500) begin
      err_count++;
      $display("Error at %0t: flush never finished", $time);
      end_sim();
    end
    chk_cnt((tx_p - t0) + 2 * (rx_p - r0), rx ? 2 : 1);
    chk({dtx, drx}, {e_tx, e_rx});
    chk(sel, e_filt);
  endtask

  // set a filter code, then a glitch of n cycles must vanish and one of n+2 pass
  task automatic filt(input logic [1:0] code, input int n);
    int w, b0;
    @(posedge ref_clk);
    filt_wr <= 1'b1;
    fdat <= code;
    e_filt = code;
    @(posedge ref_clk);
    filt_wr <= 1'b0;
    #1;
    chk(sel, code);
    // three synchroniser edges plus one for the agreeing copy on the link side
    repeat (4) @(posedge link_clk);
    for (int k = 0; k < 4; k++) begin
      w = k[0] ? n + 2 : n;
      if (w > 0) begin
        b0 = k[1] ? scl_lo : sda_lo;
        p.pull(k[1], w);
        repeat (n + 8) @(posedge link_clk);
        chk({1'b0, (k[1] ? scl_lo : sda_lo) != b0}, {1'b0, w > n});
      end
    end
  endtask

  // main sequence
  initial begin
    int r;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    #1;
    chk({tx_fl, rx_fl}, 2'h0);
    chk({dtx, drx}, 2'h0);
    chk(sel, FILT_RESET);
    // random traffic; repeated sampling of a held write is harmless
    for (int i = 0; i < 200; i++) begin
      r = $random(seed);
      @(posedge ref_clk);
      dma_wr <= r[0];
      tdat <= r[1];
      rdat <= r[2] & ~r[1];
      eot <= (r[4:3] == 2'h0);
      node_on <= (r[7:5] != 3'h0);
      filt_wr <= r[8];
      fdat <= r[10:9];
      if (r[7:5] == 3'h0) {e_tx, e_rx, e_filt} = 4'h0;
      else if (r[4:3] == 2'h0) {e_tx, e_rx} = 2'h0;
      else if (r[0]) {e_tx, e_rx} = {r[1], r[2] & ~r[1]};
      if (r[7:5] != 3'h0 && r[8]) e_filt = r[10:9];
      @(posedge ref_clk);
      #1;
      chk({dtx, drx}, {e_tx, e_rx});
      chk(sel, e_filt);
    end
    // only the tx enable is written: both enables at once is forbidden
    @(posedge ref_clk);
    {eot, filt_wr, node_on, dma_wr, tdat, rdat} <= 6'h0E;
    @(posedge ref_clk);
    dma_wr <= 1'b0;
    {e_tx, e_rx} = 2'h2;
    flush(1'b0);
    flush(1'b1);
    filt(FILT_OFF, 0);
    filt(FILT_ONE, FILT_CNT_ONE);
    filt(FILT_TWO, FILT_CNT_TWO);
    filt(FILT_FOUR, FILT_CNT_FOUR);
    end_sim();
  end
endmodule
